// *** design/pbt_core.sv ***
`timescale 1ns/1ps
// Behaviour
// [R1] Target releases TRDY#, STOP#, DEVSEL# the clock after the last data phase.
// [R2] Back-end requests a disconnect when a burst would cross its resource.
// [R3] Target releases STOP# the cycle after FRAME# is seen deasserted.
// [R4] STOP# stays asserted until the initiator negates FRAME#.
// [R5] A stop always ends the transaction; data never resumes after STOP#.
// [R6] TRDY# is deasserted whenever target-abort is signalled.
// [R7] First data phase completes or terminates within 16 clocks.
// [R8] DEVSEL# comes before or with TRDY# or STOP#.
// [R9] DEVSEL# held until last data phase, dropped only for target-abort.
// [R10] Special-cycle commands are never claimed.
// [R11] PAR is driven one clock after AD and C/BE#.
// [R12] PAR makes AD, C/BE and PAR together hold an even count of ones.
// [R13] No locked transactions; lock signal never driven.
// [R14] Unclaimed initiator cycle ends in master abort and sets its flag.
// [R15] On master abort FRAME# and IRDY# release one clock late.
// [R16] Target-abort seen by initiator sets received_target_abort_flag.
// [R17] Back-end checks received_target_abort_flag and never reissues.
// [R18] Initiator completes with fast, medium, slow and subtractive targets.
// [R19] Initiator starts only with grant, idle bus and master enable.
// [R20] Master abort no earlier than 5 clocks after FRAME# sampled.
// [R21] Status flags clear only on a written one; set wins.
module pbt_core (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        frame_n_bus,
  output logic             frame_n_drv,
  output logic             frame_n_en,
  input  wire logic        irdy_n_bus,
  output logic             irdy_n_drv,
  output logic             irdy_n_en,
  input  wire logic        trdy_n_bus,
  output logic             trdy_n_drv,
  output logic             trdy_n_en,
  input  wire logic        stop_n_bus,
  output logic             stop_n_drv,
  output logic             stop_n_en,
  input  wire logic        devsel_n_bus,
  output logic             devsel_n_drv,
  output logic             devsel_n_en,
  input  wire logic [31:0] ad_bus,
  output logic [31:0]      ad_drv,
  output logic             ad_en,
  input  wire logic [3:0]  cbe_n_bus,
  output logic [3:0]       cbe_n_drv,
  output logic             cbe_n_en,
  output logic             par_drv,
  output logic             par_en,
  output logic             lock_n_en,
  input  wire logic        idsel,
  input  wire logic        gnt_n,
  output logic             req_n,
  input  wire logic        t_hit,
  input  wire logic        t_ready,
  input  wire logic        t_stop,
  input  wire logic        t_abort,
  input  wire logic [31:0] t_rdata,
  output logic             t_start,
  output logic [31:0]      t_addr,
  output logic [3:0]       t_cmd,
  output logic             t_wr,
  output logic             t_rd,
  output logic [31:0]      t_wdata,
  output logic [3:0]       t_be_n,
  input  wire logic        master_en,
  input  wire logic        m_req,
  input  wire logic [3:0]  m_cmd,
  input  wire logic [31:0] m_addr,
  input  wire logic [31:0] m_wdata,
  input  wire logic [3:0]  m_be_n,
  input  wire logic        m_last,
  input  wire logic        m_ready,
  output logic [31:0]      m_rdata,
  output logic             m_xfer,
  output logic             m_done,
  output logic             mabort_flag,
  output logic             received_target_abort_flag,
  input  wire logic        mabort_clr,
  input  wire logic        rtabort_clr
);
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_ABORT, T_TURN} pbt_tgt_e;
  localparam int INIT_LAT = pbt_pkg::INIT_LAT_CLKS;

  pbt_tgt_e          st_reg, st_next;
  logic              devsel_reg, devsel_next;
  logic              trdy_reg, trdy_next;
  logic              stop_reg, stop_next;
  logic              en_reg, en_next;
  logic              aden_reg, aden_next;
  logic              first_reg, first_next;
  logic [pbt_pkg::LAT_W-1:0] lat_reg, lat_next;
  logic [31:0]       ad_reg, ad_next;
  logic              idle_reg, idle_next;
  logic              rd_reg, rd_next;
  logic              start_reg, start_next;
  logic              wr_reg, wr_next;
  logic              rdp_reg, rdp_next;
  logic [31:0]       addr_reg, addr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        cmd_reg, cmd_next;
  logic [3:0]        be_reg, be_next;
  logic              addr_ph, is_cfg, claim, xfer, pdone, last, lat_exp;
  logic              i_fi_drv_f, i_ir_drv, i_ctl_en, i_ad_en, i_cbe_en;
  logic [31:0]       i_ad;
  logic [3:0]        i_cbe;

  // ----------------------------------------
  // Address phase decode
  // ----------------------------------------
  assign addr_ph = idle_reg & ~frame_n_bus;
  assign is_cfg  = cbe_n_bus[3:1] == pbt_pkg::CMD_CFG_HI;
  // Never claim our own initiator cycle
  assign claim   = addr_ph & ~i_ctl_en
                   & (cbe_n_bus != pbt_pkg::CMD_SPECIAL)   // [R10]
                   & (is_cfg ? (idsel & (ad_bus[1:0] == pbt_pkg::CFG_TYPE0)) : t_hit);
  assign xfer    = trdy_reg & ~irdy_n_bus;
  assign pdone   = xfer | (stop_reg & ~irdy_n_bus);
  assign last    = pdone & frame_n_bus;
  assign lat_exp = first_reg & (lat_reg >= pbt_pkg::LAT_STOP);

  // ----------------------------------------
  // Target handshake
  // ----------------------------------------
  always_comb begin
    st_next = st_reg; devsel_next = devsel_reg; trdy_next = trdy_reg;
    stop_next = stop_reg; en_next = en_reg; aden_next = aden_reg;
    first_next = first_reg; lat_next = lat_reg;
    ad_next = (trdy_reg & ~xfer) ? ad_reg : t_rdata;
    case (st_reg)
      T_IDLE: begin
        en_next = 1'b0;
        aden_next = 1'b0;
        if (claim) begin
          st_next = T_DATA;
          devsel_next = 1'b1;                     // [R8]
          en_next = 1'b1;
          first_next = 1'b1;
          lat_next = pbt_pkg::LAT_START;
        end
      end
      T_DATA: begin
        aden_next = rd_reg;
        if (first_reg) lat_next = lat_reg + 5'h1;
        if (pdone) first_next = 1'b0;
        if (last) begin
          st_next = T_TURN;                       // [R1] [R3]
          devsel_next = 1'b0;
          trdy_next = 1'b0;
          stop_next = 1'b0;
          aden_next = 1'b0;
        end else if (trdy_reg & ~pdone) begin
          // Handshake frozen until the data phase completes
        end else if (stop_reg) begin
          trdy_next = 1'b0;                       // [R4] [R5]
        end else if (t_abort) begin
          st_next = T_ABORT;                      // [R6] [R9]
          devsel_next = 1'b0;
          trdy_next = 1'b0;
          stop_next = 1'b1;
          aden_next = 1'b0;
        end else begin
          stop_next = t_stop | lat_exp;           // [R7]
          trdy_next = t_ready & ~lat_exp;
        end
      end
      T_ABORT: begin
        if (frame_n_bus & ~irdy_n_bus) begin
          st_next = T_TURN;                       // [R3]
          stop_next = 1'b0;
        end
      end
      T_TURN: begin
        // Drove the lines high for one clock; now let go
        en_next = 1'b0;
        aden_next = 1'b0;
        st_next = T_IDLE;
      end
      default: st_next = T_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg     <= T_IDLE;
      devsel_reg <= 1'b0;
      trdy_reg   <= 1'b0;
      stop_reg   <= 1'b0;
      en_reg     <= 1'b0;
      aden_reg   <= 1'b0;
      first_reg  <= 1'b0;
      lat_reg    <= '0;
      ad_reg     <= '0;
    end else if (ce) begin
      st_reg     <= st_next;
      devsel_reg <= devsel_next;
      trdy_reg   <= trdy_next;
      stop_reg   <= stop_next;
      en_reg     <= en_next;
      aden_reg   <= aden_next;
      first_reg  <= first_next;
      lat_reg    <= lat_next;
      ad_reg     <= ad_next;
    end
  end

  // ----------------------------------------
  // Back-end capture
  // ----------------------------------------
  always_comb begin
    idle_next  = frame_n_bus & irdy_n_bus;
    start_next = claim;
    rd_next    = claim ? ~cbe_n_bus[pbt_pkg::CMD_WR_BIT] : rd_reg;
    addr_next  = claim ? ad_bus : addr_reg;
    cmd_next   = claim ? cbe_n_bus : cmd_reg;
    wr_next    = xfer & ~rd_reg & (st_reg == T_DATA);
    rdp_next   = xfer & rd_reg & (st_reg == T_DATA);
    wdata_next = wr_next ? ad_bus : wdata_reg;
    be_next    = wr_next ? cbe_n_bus : be_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idle_reg  <= 1'b0;
      start_reg <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
      cmd_reg   <= '0;
      wr_reg    <= 1'b0;
      rdp_reg   <= 1'b0;
      wdata_reg <= '0;
      be_reg    <= '0;
    end else if (ce) begin
      idle_reg  <= idle_next;
      start_reg <= start_next;
      rd_reg    <= rd_next;
      addr_reg  <= addr_next;
      cmd_reg   <= cmd_next;
      wr_reg    <= wr_next;
      rdp_reg   <= rdp_next;
      wdata_reg <= wdata_next;
      be_reg    <= be_next;
    end
  end

  // ----------------------------------------
  // Initiator and parity
  // ----------------------------------------
  pbt_initiator u_ini (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .ce           (ce),
    .frame_n_bus  (frame_n_bus),
    .irdy_n_bus   (irdy_n_bus),
    .trdy_n_bus   (trdy_n_bus),
    .stop_n_bus   (stop_n_bus),
    .devsel_n_bus (devsel_n_bus),
    .gnt_n        (gnt_n),
    .ad_bus       (ad_bus),
    .master_en    (master_en),
    .m_req        (m_req),
    .m_cmd        (m_cmd),
    .m_addr       (m_addr),
    .m_wdata      (m_wdata),
    .m_be_n       (m_be_n),
    .m_last       (m_last),
    .m_ready      (m_ready),
    .mabort_clr   (mabort_clr),
    .rtabort_clr  (rtabort_clr),
    .frame_n_drv  (i_fi_drv_f),
    .irdy_n_drv   (i_ir_drv),
    .ctl_en       (i_ctl_en),
    .req_n        (req_n),
    .ad_drv       (i_ad),
    .ad_en        (i_ad_en),
    .cbe_drv      (i_cbe),
    .cbe_en       (i_cbe_en),
    .m_rdata      (m_rdata),
    .m_xfer       (m_xfer),
    .m_done       (m_done),
    .mabort_flag  (mabort_flag),
    .received_target_abort_flag (received_target_abort_flag)
  );

  pbt_parity u_par (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .ad      (ad_drv),
    .cbe_n   (i_cbe_en ? i_cbe : cbe_n_bus),
    .drive   (ad_en),
    .par_drv (par_drv),
    .par_en  (par_en)
  );

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign frame_n_drv  = i_fi_drv_f;
  assign frame_n_en   = i_ctl_en;
  assign irdy_n_drv   = i_ir_drv;
  assign irdy_n_en    = i_ctl_en;
  assign trdy_n_drv   = ~trdy_reg;
  assign trdy_n_en    = en_reg;
  assign stop_n_drv   = ~stop_reg;
  assign stop_n_en    = en_reg;
  assign devsel_n_drv = ~devsel_reg;
  assign devsel_n_en  = en_reg;
  assign ad_drv       = aden_reg ? ad_reg : i_ad;
  assign ad_en        = aden_reg | i_ad_en;
  assign cbe_n_drv    = i_cbe;
  assign cbe_n_en     = i_cbe_en;
  // Lock is never taken part in, so its driver stays off
  assign lock_n_en    = 1'b0;                     // [R13]
  assign t_start      = start_reg;
  assign t_addr       = addr_reg;
  assign t_cmd        = cmd_reg;
  assign t_wr         = wr_reg;
  assign t_rd         = rdp_reg;
  assign t_wdata      = wdata_reg;
  assign t_be_n       = be_reg;

  // ----------------------------------------
  // Protocol checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || !ce);

  rel_after_last_a: assert property ( // [R1]
    st_reg == T_DATA && last |=> !trdy_reg && !stop_reg && !devsel_reg)
    else $error("target lines not released after last phase");
  stop_release_a: assert property ( // [R3]
    stop_reg && frame_n_bus && !irdy_n_bus |=> !stop_reg)
    else $error("stop held after frame negated");
  stop_hold_a: assert property ( // [R4]
    stop_reg && !frame_n_bus |=> stop_reg)
    else $error("stop dropped while frame asserted");
  no_resume_a: assert property ( // [R5]
    stop_reg && !frame_n_bus && pdone |=> !trdy_reg [*2])
    else $error("data resumed after stop");
  abort_trdy_a: assert property ( // [R6]
    stop_reg && !devsel_reg |-> !trdy_reg)
    else $error("trdy asserted during target abort");
  init_lat_a: assert property ( // [R7]
    first_reg && st_reg == T_DATA |-> lat_reg < INIT_LAT || stop_reg)
    else $error("initial latency exceeded");
  devsel_first_a: assert property ( // [R8]
    trdy_reg || (stop_reg && st_reg == T_DATA) |-> devsel_reg)
    else $error("response without devsel");
  devsel_hold_a: assert property ( // [R9]
    $fell(devsel_reg) |-> stop_reg || $past(last))
    else $error("devsel dropped early");
  no_special_a: assert property ( // [R10]
    addr_ph && cbe_n_bus == pbt_pkg::CMD_SPECIAL |=> !devsel_reg)
    else $error("special cycle claimed");
  par_follow_a: assert property ( // [R11]
    ad_en |=> par_en)
    else $error("par not driven after ad");
endmodule

// *** design/pbt_pkg.sv ***
package pbt_pkg;
  // ----------------------------------------
  // Bus command encodings
  // ----------------------------------------
  localparam logic [3:0] CMD_SPECIAL   = 4'h1;
  localparam logic [2:0] CMD_CFG_HI    = 3'h5;
  localparam logic [1:0] CFG_TYPE0     = 2'h0;
  localparam int         CMD_WR_BIT    = 0;
  // ----------------------------------------
  // Timing in bus clocks; the clock period is given in ns
  // ----------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         INIT_LAT_CLKS = 16;
  localparam int         LAT_W         = 5;
  localparam logic [4:0] LAT_STOP      = 5'(INIT_LAT_CLKS - 1);
  localparam logic [4:0] LAT_START     = 5'h1;
  localparam int         MABORT_CLKS   = 5;
  localparam logic [2:0] MABORT_LAST   = 3'(MABORT_CLKS - 1);
  localparam logic [2:0] DEC_START     = 3'h1;
endpackage

// *** design/pbt_parity.sv ***
`timescale 1ns/1ps
module pbt_parity (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  input  wire logic        drive,
  output logic             par_drv,
  output logic             par_en
);
  logic par_reg;
  logic par_next;
  logic en_reg;
  logic en_next;

  // ----------------------------------------
  // Even parity, one clock behind AD
  // ----------------------------------------
  always_comb begin
    par_next = ^{ad, cbe_n};                      // [R12]
    en_next  = drive;                             // [R11]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      par_reg <= 1'b0;
      en_reg  <= 1'b0;
    end else if (ce) begin
      par_reg <= par_next;
      en_reg  <= en_next;
    end
  end

  assign par_drv = par_reg;
  assign par_en  = en_reg;

  par_even_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !ce) // [R12]
    drive |=> par_en && (par_drv == ^$past({ad, cbe_n})))
    else $error("parity not even or late");
endmodule

// *** design/pbt_initiator.sv ***
`timescale 1ns/1ps
module pbt_initiator (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        frame_n_bus,
  input  wire logic        irdy_n_bus,
  input  wire logic        trdy_n_bus,
  input  wire logic        stop_n_bus,
  input  wire logic        devsel_n_bus,
  input  wire logic        gnt_n,
  input  wire logic [31:0] ad_bus,
  input  wire logic        master_en,
  input  wire logic        m_req,
  input  wire logic [3:0]  m_cmd,
  input  wire logic [31:0] m_addr,
  input  wire logic [31:0] m_wdata,
  input  wire logic [3:0]  m_be_n,
  input  wire logic        m_last,
  input  wire logic        m_ready,
  input  wire logic        mabort_clr,
  input  wire logic        rtabort_clr,
  output logic             frame_n_drv,
  output logic             irdy_n_drv,
  output logic             ctl_en,
  output logic             req_n,
  output logic [31:0]      ad_drv,
  output logic             ad_en,
  output logic [3:0]       cbe_drv,
  output logic             cbe_en,
  output logic [31:0]      m_rdata,
  output logic             m_xfer,
  output logic             m_done,
  output logic             mabort_flag,
  output logic             received_target_abort_flag
);
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_MABORT, M_TURN} pbt_ini_e;
  pbt_ini_e    st_reg, st_next;
  logic        frame_reg, frame_next, irdy_reg, irdy_next, en_reg, en_next;
  logic        aden_reg, aden_next, cbeen_reg, cbeen_next, wr_reg, wr_next;
  logic        seen_reg, seen_next, xf_reg, xf_next, dn_reg, dn_next;
  logic        ma_reg, ma_next, ta_reg, ta_next, rq_reg, rq_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [3:0]  cbe_reg, cbe_next;
  logic [31:0] ad_reg, ad_next, rd_reg, rd_next;
  logic        xfer, stp, tabort, ma_set;

  localparam logic [2:0] MABORT_LAST_C = pbt_pkg::MABORT_LAST;
  assign xfer   = irdy_reg & ~trdy_n_bus;
  assign stp    = (st_reg == M_DATA) & ~stop_n_bus;
  assign tabort = stp & devsel_n_bus & seen_reg;
  // Fast, medium, slow and subtractive claims all land before the count ends
  assign ma_set = (st_reg == M_DATA) & ~seen_reg & devsel_n_bus
                  & (cnt_reg == MABORT_LAST_C);   // [R18] [R20]

  // ----------------------------------------
  // Initiator sequencing
  // ----------------------------------------
  always_comb begin
    st_next = st_reg; frame_next = frame_reg; irdy_next = irdy_reg;
    en_next = en_reg; aden_next = aden_reg; cbeen_next = cbeen_reg;
    wr_next = wr_reg; seen_next = seen_reg; cnt_next = cnt_reg;
    cbe_next = cbe_reg; ad_next = ad_reg; rd_next = rd_reg;
    xf_next = 1'b0; dn_next = 1'b0;
    rq_next = m_req & (st_reg == M_IDLE);
    case (st_reg)
      M_IDLE: begin
        en_next = 1'b0; aden_next = 1'b0; cbeen_next = 1'b0;
        if (m_req & ~gnt_n & frame_n_bus & irdy_n_bus & master_en) begin // [R19]
          st_next = M_ADDR; frame_next = 1'b1; en_next = 1'b1;
          ad_next = m_addr; aden_next = 1'b1; cbe_next = m_cmd; cbeen_next = 1'b1;
          wr_next = m_cmd[pbt_pkg::CMD_WR_BIT]; seen_next = 1'b0;
        end
      end
      M_ADDR: begin
        st_next = M_DATA; cnt_next = pbt_pkg::DEC_START;
        cbe_next = m_be_n; ad_next = m_wdata; aden_next = wr_reg;
        irdy_next = m_ready; frame_next = ~(m_last & m_ready);
      end
      M_DATA: begin
        if (~devsel_n_bus) seen_next = 1'b1;
        else if (~seen_reg) cnt_next = cnt_reg + 3'h1;
        if (ma_set) begin
          st_next = M_MABORT;                     // [R14]
        end else if (stp) begin
          xf_next = xfer;
          if (xfer & ~wr_reg) rd_next = ad_bus;
          if (frame_reg) begin
            frame_next = 1'b0; irdy_next = 1'b1;
          end else begin
            irdy_next = 1'b0; st_next = M_TURN;
          end
        end else if (xfer) begin
          xf_next = 1'b1;
          if (~wr_reg) rd_next = ad_bus;
          if (~frame_reg) begin
            irdy_next = 1'b0; st_next = M_TURN;
          end else begin
            irdy_next = m_ready; frame_next = ~(m_last & m_ready);
            ad_next = m_wdata; cbe_next = m_be_n;
          end
        end else if (~irdy_reg) begin
          irdy_next = m_ready; frame_next = ~(m_last & m_ready);
          ad_next = m_wdata; cbe_next = m_be_n;
        end
      end
      M_MABORT: begin
        // Frame held one clock past the abort decision
        if (frame_reg) begin
          frame_next = 1'b0; irdy_next = 1'b1;    // [R15]
        end else begin
          irdy_next = 1'b0; st_next = M_TURN;
        end
      end
      M_TURN: begin
        en_next = 1'b0; aden_next = 1'b0; cbeen_next = 1'b0;
        dn_next = 1'b1; st_next = M_IDLE;
      end
      default: st_next = M_IDLE;
    endcase
    ma_next = ma_set | (ma_reg & ~mabort_clr);    // [R14] [R21]
    ta_next = tabort | (ta_reg & ~rtabort_clr);   // [R16] [R21]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= M_IDLE; frame_reg <= 1'b0; irdy_reg <= 1'b0; en_reg <= 1'b0;
      aden_reg <= 1'b0; cbeen_reg <= 1'b0; wr_reg <= 1'b0; seen_reg <= 1'b0;
      cnt_reg <= '0; cbe_reg <= '0; ad_reg <= '0; rd_reg <= '0; xf_reg <= 1'b0;
      dn_reg <= 1'b0; ma_reg <= 1'b0; ta_reg <= 1'b0; rq_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next; frame_reg <= frame_next; irdy_reg <= irdy_next;
      en_reg <= en_next; aden_reg <= aden_next; cbeen_reg <= cbeen_next;
      wr_reg <= wr_next; seen_reg <= seen_next; cnt_reg <= cnt_next;
      cbe_reg <= cbe_next; ad_reg <= ad_next; rd_reg <= rd_next; xf_reg <= xf_next;
      dn_reg <= dn_next; ma_reg <= ma_next; ta_reg <= ta_next; rq_reg <= rq_next;
    end
  end

  assign frame_n_drv = ~frame_reg;
  assign irdy_n_drv  = ~irdy_reg;
  assign ctl_en      = en_reg;
  assign req_n       = ~rq_reg;
  assign ad_drv      = ad_reg;
  assign ad_en       = aden_reg;
  assign cbe_drv     = cbe_reg;
  assign cbe_en      = cbeen_reg;
  assign m_rdata     = rd_reg;
  assign m_xfer      = xf_reg;
  assign m_done      = dn_reg;
  assign mabort_flag = ma_reg;
  assign received_target_abort_flag = ta_reg;

  ma_late_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !ce) // [R20]
    $rose(ma_reg) |-> $past(cnt_reg) == MABORT_LAST_C && $past(st_reg) == M_DATA)
    else $error("master abort declared too early");
  ta_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !ce) // [R16]
    tabort |=> received_target_abort_flag)
    else $error("target abort not recorded");
  start_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !ce) // [R19]
    st_reg == M_IDLE && st_next == M_ADDR |-> !gnt_n && master_en && frame_n_bus)
    else $error("start without grant or enable");
endmodule

// *** tb/pbt_agent.sv ***
`timescale 1ns/1ps
// Far-side agents: an initiator for the target path, a target for the initiator path
module pbt_agent (
  input  wire logic   clk_sys, frame_n_bus, irdy_n_bus, trdy_n_bus, stop_n_bus,
  output logic        a_frame_n, a_irdy_n, a_trdy_n, a_stop_n, a_devsel_n,
  output logic [31:0] a_ad,
  output logic [3:0]  a_cbe_n
);
  initial {a_frame_n, a_irdy_n, a_trdy_n, a_stop_n, a_devsel_n, a_cbe_n, a_ad} = '1;
  // Released AD shows the inverse, so stale data cannot pass for a drive
  task automatic init_cycle(input logic [3:0] cmd, input logic [31:0] data, input logic hold, output int n);
    @(posedge clk_sys) #1 {a_frame_n, a_cbe_n, a_ad} = {1'b0, cmd, 32'h100};
    @(posedge clk_sys) #1 {a_frame_n, a_irdy_n, a_cbe_n, a_ad} = {~hold, 1'b0, 4'h0, data};
    n = 0;
    do @(posedge clk_sys); while (trdy_n_bus && stop_n_bus && n++ < 20);
    // A held frame drops first, with irdy kept low one more phase
    if (hold) begin
      #1 a_frame_n = 1'b1;
      @(posedge clk_sys);
    end
    #1 {a_irdy_n, a_cbe_n, a_ad} = {5'h1F, ~data};
  endtask
  task automatic answer(input int dly, input logic abort);
    int n;
    n = 0;
    do @(posedge clk_sys); while (frame_n_bus && n++ < 40);
    repeat (dly) @(posedge clk_sys);
    #1 {a_devsel_n, a_trdy_n} = {1'b0, abort};
    if (abort) @(posedge clk_sys) #1 {a_devsel_n, a_stop_n} = 2'b10;
    n = 0;
    do @(posedge clk_sys); while ((irdy_n_bus || !frame_n_bus) && n++ < 40);
    #1 {a_devsel_n, a_trdy_n, a_stop_n} = '1;
  endtask
endmodule

// *** tb/bus_target_initiator_protocol_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module bus_target_initiator_protocol_tb;
  logic        clk_sys = 0, sys_rst = 1, ce = 1, idsel = 0, gnt_n = 1, t_hit = 1, t_ready = 1, t_stop = 0;
  logic        t_abort = 0, master_en = 1, m_req = 0, m_last = 1, m_ready = 1, mabort_clr = 0, rtabort_clr = 0;
  logic [3:0]  m_cmd = 4'h7, m_be_n = 4'h0, cbe_n_drv, t_cmd, t_be_n, a_cbe_n, pcbe;
  logic [31:0] t_rdata = 32'h0, m_addr = 32'h200, m_wdata = 32'hC3C3_5A5A, ad_drv, t_addr, t_wdata, m_rdata, a_ad, pad, wcap;
  logic        frame_n_drv, frame_n_en, irdy_n_drv, irdy_n_en, trdy_n_drv, trdy_n_en, stop_n_drv, stop_n_en, t_rd;
  logic        devsel_n_drv, devsel_n_en, ad_en, cbe_n_en, par_drv, par_en, lock_n_en, req_n, t_start, t_wr, pdrv = 0;
  logic        m_xfer, m_done, mabort_flag, received_target_abort_flag, a_frame_n, a_irdy_n, a_trdy_n, a_stop_n, a_devsel_n;
  logic [2:0]  seen = 0;
  int          bad_count = 0, n_compared = 0, n, frame_cnt = 0;
  wire         frame_n_bus = (frame_n_en ? frame_n_drv : 1'b1) & a_frame_n;
  wire         irdy_n_bus = (irdy_n_en ? irdy_n_drv : 1'b1) & a_irdy_n;
  wire         trdy_n_bus = (trdy_n_en ? trdy_n_drv : 1'b1) & a_trdy_n;
  wire         stop_n_bus = (stop_n_en ? stop_n_drv : 1'b1) & a_stop_n;
  wire         devsel_n_bus = (devsel_n_en ? devsel_n_drv : 1'b1) & a_devsel_n;
  wire  [31:0] ad_bus = ad_en ? ad_drv : a_ad;
  wire  [3:0]  cbe_n_bus = cbe_n_en ? cbe_n_drv : a_cbe_n;
  always #5 clk_sys = ~clk_sys;
  pbt_core pbt_core_inst (.*);
  pbt_agent pbt_agent_inst (.*);
  always @(posedge clk_sys) if (!sys_rst) begin
    seen <= seen | {devsel_n_en & ~devsel_n_drv, trdy_n_en & ~trdy_n_drv, stop_n_en & ~stop_n_drv};
    frame_cnt <= frame_cnt + int'(!frame_n_bus);
    if (t_wr) wcap <= t_wdata;
    `CHK("par_en", pdrv, par_en)
    if (pdrv) `CHK("parity", 1'b0, ^{pad, pcbe, par_drv})
    {pdrv, pad, pcbe} <= {ad_en, ad_bus, cbe_n_bus};
  end
  task automatic tgt(input logic [3:0] cmd, input logic [2:0] exp, input int max_n);
    seen = 3'h0;
    pbt_agent_inst.init_cycle(cmd, 32'hA5A5_0F0F, t_stop, n);
    `CHK("responses", exp, seen)
    if (exp[2]) `CHK("claim", {32'h100, cmd}, {t_addr, t_cmd})
    `CHK("first phase", 1'b1, n <= max_n)
    `CHK("released", 2'b11, {devsel_n_drv, stop_n_drv})
  endtask
  task automatic ini(input int dly, input logic abort, input logic [1:0] exp);
    frame_cnt = 0;
    fork
      if (dly >= 0) pbt_agent_inst.answer(dly, abort);
      begin
        {m_req, gnt_n} = 2'b10;
        do @(posedge clk_sys); while (!frame_n_en);
        // Start taken; a request still up would open a second cycle
        #1 m_req = 1'b0;
        n = 0;
        do @(posedge clk_sys); while (!m_done && n++ < 40);
        #1 gnt_n = 1'b1;
      end
    join
    `CHK("flags", {1'b1, exp}, {n <= 40, mabort_flag, received_target_abort_flag})
    if (!m_cmd[0]) `CHK("read data", ~32'hA5A5_0F0F, m_rdata)
  endtask
  task automatic clr(input logic [1:0] which, input logic [1:0] exp);
    {mabort_clr, rtabort_clr} = which;
    @(posedge clk_sys) #1 {mabort_clr, rtabort_clr} = 2'b00;
    `CHK("after clear", exp, {mabort_flag, received_target_abort_flag})
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Whole run is a few hundred clocks; the limit leaves ample margin
  initial begin
    #30000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 0;
    repeat (2) @(posedge clk_sys);
    #1 tgt(4'h7, 3'b110, 15);
    @(posedge clk_sys) #1 `CHK("write data", 32'hA5A5_0F0F, wcap)
    tgt(pbt_pkg::CMD_SPECIAL, 3'b000, 21);
    tgt(4'hB, 3'b000, 21);
    idsel = 1;
    tgt(4'hB, 3'b110, 15);
    {idsel, t_stop} = 2'b01;
    tgt(4'h7, 3'b111, 15);
    t_stop = 0;
    tgt(4'h6, 3'b110, 15);
    t_abort = 1;
    tgt(4'h7, 3'b101, 15);
    {t_abort, t_ready} = 2'b00;
    tgt(4'h7, 3'b101, 15);
    {t_ready, m_last} = 2'b10;
    ini(-1, 0, 2'b10);
    m_last = 1;
    `CHK("frame length", 6, frame_cnt)
    clr(2'b10, 2'b00);
    for (int d = 0; d < 8; d++) begin
      m_cmd = {d[0] ? 3'h1 : 3'h5, d[2]};
      ini(d % 4, 0, 2'b00);
    end
    // Abort is not retried: the back-end only clears the flag
    ini(1, 1, 2'b01);
    clr(2'b10, 2'b01);
    clr(2'b01, 2'b00);
    {master_en, m_req, gnt_n, frame_cnt} = {3'b010, 32'd0};
    repeat (10) @(posedge clk_sys);
    `CHK("no start", 0, frame_cnt)
    `CHK("lock", 1'b0, lock_n_en)
    stop_test;
  end
endmodule
